// ---- rtl/synth_ctrl.sv ----
// Mode, waveform, boost, channel and data entry control for two channels.
// What this block does
// - Mode key cycles four modes, one indicator lit.
// - Shift then mode toggles summed output instead.
// - Entering two-phase or pulse runs phase calibration.
// - Both outputs disabled during a mode change.
// - Independent channels; second channel modulates first.
// - Two-phase shares frequency, phase offset kept.
// - Two-tone second follows first, difference max 100k.
// - Pulse mode drives second square inverted first.
// - Summed output halves level limit, zeroes offset.
// - Summed offset only with dc; others zero it.
// - Summed allowed in three modes, not with modulation.
// - Second connector dark while summed or modulating.
// - Function key cycles off, sine, square, dc.
// - Pulse mode function cycle only off and square.
// - Dc function outputs entered offset level only.
// - Shift then function toggles boost if option fitted.
// - Boost allows 40 V, refuses above 1 MHz.
// - Mode change above 1 MHz drops second boost.
// - Channel key toggles target channel and indicators.
// - Parameter, digits, units; new parameter abandons entry.
// - Out of range value discarded with error.
// - Backspace drops last digit or decimal point.
// - Keys under remote control rejected with error.
module synth_ctrl (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire synth_ctrl_pkg::key_s  i_key,
  input  wire logic                  i_remote_mode,
  input  wire logic                  i_boost_option,
  input  wire logic                  i_sqr_a,
  input  wire logic                  i_sqr_b,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  output synth_ctrl_pkg::cfg_s       o_cfg_a,
  output synth_ctrl_pkg::cfg_s       o_cfg_b,
  output synth_ctrl_pkg::panel_s     o_panel,
  output logic                       o_mode_busy,
  output logic                       o_cal_run,
  output logic                       o_b_connector_en,
  output logic                       o_mod_from_b,
  output logic                       o_sqr_out_b,
  output logic                       o_err_strobe
);
  import synth_ctrl_pkg::*;

  logic [1:0]  remote_sync_q, opt_sync_q;
  logic        remote, boost_opt;
  mode_e       mode_q, mode_new;
  seq_e        seq_q;
  logic [11:0] cnt_q;
  logic        comb_q, int_mod_q, target_channel_toggle_q, shift_q;
  wave_e       wave_q [2];
  logic [1:0]  boost_q;
  logic [31:0] freq_q [2];
  logic [15:0] level_q [2], ofs_q [2], phase_q [2];
  logic [7:0]  err_code_q;
  logic        err_flag_q, err_pulse_q, sqr_b_q;
  logic        entry_q, point_q;
  param_e      param_q;
  logic [31:0] mant_q;
  logic [1:0]  frac_q;
  logic        addr_ok, apb_acc, apb_wr, cmd_wr, ctrl_wr, err_wr;
  logic        key_any, key_reject, key_ok;
  cmd_s        cmd;
  logic        mode_go, comb_want, comb_refuse, comb_go, apply;
  logic [1:0]  wave_refuse, boost_refuse, wave_go;
  logic [63:0] scaled;
  logic [31:0] val, lim, diff, other_max;
  logic [32:0] tone_b;
  logic        val_err;

  // Pins from the panel and option strap are asynchronous to the core.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      remote_sync_q <= 2'h0;
      opt_sync_q    <= 2'h0;
    end else begin
      remote_sync_q <= {remote_sync_q[0], i_remote_mode};
      opt_sync_q    <= {opt_sync_q[0], i_boost_option};
    end
  end
  assign remote    = remote_sync_q[1];
  assign boost_opt = opt_sync_q[1];

  // Zero wait state slave; unmapped addresses answer with an error.
  always_comb begin
    case (i_paddr)
      REG_CTRL, REG_CMD, REG_STATUS, REG_ERR, REG_FREQ_A, REG_FREQ_B,
      REG_LEVEL, REG_OFS: addr_ok = 1'b1;
      default:            addr_ok = 1'b0;
    endcase
  end
  assign apb_acc   = i_psel & i_penable;
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc & ~addr_ok;
  assign apb_wr    = apb_acc & i_pwrite & addr_ok;
  assign cmd_wr    = apb_wr & (i_paddr == REG_CMD);
  assign ctrl_wr   = apb_wr & (i_paddr == REG_CTRL);
  assign err_wr    = apb_wr & (i_paddr == REG_ERR);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0;
    end else if (i_psel & ~i_penable) begin
      case (i_paddr)
        REG_CTRL:   o_prdata <= {31'h0, int_mod_q};
        REG_STATUS: o_prdata <= status_s'{16'h0, entry_q, int_mod_q,
                                  remote, seq_q != SEQ_RUN, target_channel_toggle_q,
                                  boost_q[1], boost_q[0], wave_q[1],
                                  wave_q[0], comb_q, mode_q};
        REG_ERR:    o_prdata <= {23'h0, err_flag_q, err_code_q};
        REG_FREQ_A: o_prdata <= freq_q[0];
        REG_FREQ_B: o_prdata <= freq_q[1];
        REG_LEVEL:  o_prdata <= {level_q[1], level_q[0]};
        REG_OFS:    o_prdata <= {ofs_q[1], ofs_q[0]};
        default:    o_prdata <= 32'h0;
      endcase
    end
  end

  // A remote command and a local key share one decode path.
  always_comb begin
    key_any = i_key.mode | i_key.shift | i_key.fn_a | i_key.fn_b |
              i_key.target_channel_toggle | i_key.param_go | i_key.digit_go | i_key.point |
              i_key.bksp | i_key.units_go;
    key_reject = key_any & remote;
    key_ok     = key_any & ~remote & ~cmd_wr;
    cmd        = '0;
    if (cmd_wr) begin
      cmd     = cmd_s'(i_pwdata[5:0]);
      cmd.set = 1'b1;
    end else if (key_ok) begin
      if (i_key.mode)
        cmd.op = shift_q ? OP_COMB : OP_MODE;
      else if (i_key.fn_a)
        cmd.op = shift_q ? OP_BOOST_A : OP_FN_A;
      else if (i_key.fn_b)
        cmd.op = shift_q ? OP_BOOST_B : OP_FN_B;
      else if (i_key.target_channel_toggle)
        cmd.op = OP_TARGET_CHANNEL_TOGGLE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n)
      shift_q <= 1'b0;
    else if (key_ok)
      shift_q <= i_key.shift & ~shift_q;
  end

  always_comb begin
    mode_go  = cmd.op == OP_MODE;
    mode_new = cmd.set ? mode_e'(4'h1 << cmd.arg)
                       : mode_e'({mode_q[2:0], mode_q[3]});
    comb_want   = cmd.set ? cmd.arg[0] : ~comb_q;
    comb_refuse = (cmd.op == OP_COMB) & comb_want &
                  ((mode_q == MODE_PULSE) | int_mod_q);
    comb_go     = (cmd.op == OP_COMB) & comb_want & ~comb_refuse & ~comb_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mode_q <= MODE_TWO_CH;
      comb_q <= 1'b0;
    end else begin
      if (mode_go)
        mode_q <= mode_new;
      if (ctrl_wr & i_pwdata[CTRL_INT_MOD])
        comb_q <= 1'b0;
      else if (mode_go & (mode_new == MODE_PULSE))
        comb_q <= 1'b0;
      else if ((cmd.op == OP_COMB) & ~comb_refuse)
        comb_q <= comb_want;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      int_mod_q <= 1'b0;
      target_channel_toggle_q    <= 1'b0;
    end else begin
      if (ctrl_wr)
        int_mod_q <= i_pwdata[CTRL_INT_MOD];
      if (cmd.op == OP_TARGET_CHANNEL_TOGGLE)
        target_channel_toggle_q <= cmd.set ? cmd.arg[0] : ~target_channel_toggle_q;
    end
  end

  // Mode change: settle with outputs off, then calibrate if needed.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      seq_q <= SEQ_RUN;
      cnt_q <= 12'h0;
    end else if (mode_go) begin
      seq_q <= SEQ_SETTLE;
      cnt_q <= SETTLE_CNT;
    end else begin
      case (seq_q)
        SEQ_SETTLE: begin
          if (cnt_q != 12'h0) begin
            cnt_q <= cnt_q - 12'h1;
          end else if ((mode_q == MODE_TWO_PH) |
                       (mode_q == MODE_PULSE)) begin
            seq_q <= SEQ_CAL;
            cnt_q <= CAL_CNT;
          end else begin
            seq_q <= SEQ_RUN;
          end
        end
        SEQ_CAL: begin
          if (cnt_q != 12'h0)
            cnt_q <= cnt_q - 12'h1;
          else
            seq_q <= SEQ_RUN;
        end
        default: seq_q <= SEQ_RUN;
      endcase
    end
  end

  // Entered mantissa is scaled by the units key and the decimal places.
  function automatic logic [63:0] scale(input logic [31:0] m,
                                        input logic [1:0]  u,
                                        input logic [1:0]  f);
    logic [63:0] p;
    case (u)
      2'h1:    p = {32'h0, m} * 64'h3e8;
      2'h2:    p = {32'h0, m} * 64'hf4240;
      default: p = {32'h0, m};
    endcase
    case (f)
      2'h1:    p = p / 64'ha;
      2'h2:    p = p / 64'h64;
      2'h3:    p = p / 64'h3e8;
      default: p = p;
    endcase
    return p;
  endfunction

  always_comb begin
    apply  = key_ok & i_key.units_go & entry_q;
    scaled = scale(mant_q, i_key.units, frac_q);
    val    = scaled[31:0];
    tone_b = {1'b0, freq_q[1]} + {1'b0, val} - {1'b0, freq_q[0]};
    diff   = (val >= freq_q[0]) ? val - freq_q[0] : freq_q[0] - val;
    lim    = boost_q[target_channel_toggle_q] ? BOOST_LEVEL : LEVEL_MAX;
    if (comb_q)
      lim = lim >> 1;
    other_max = boost_q[~target_channel_toggle_q] ? BOOST_FMAX : FREQ_MAX_HZ;
    val_err   = |scaled[63:32];
    case (param_q)
      PAR_FREQ: begin
        if (val > (boost_q[target_channel_toggle_q] ? BOOST_FMAX : FREQ_MAX_HZ))
          val_err = 1'b1;
        if ((mode_q == MODE_TWO_PH) & (val > other_max))
          val_err = 1'b1;
        if ((mode_q == MODE_TWO_TONE) & ~target_channel_toggle_q &
            (tone_b[32] | (tone_b[31:0] > other_max)))
          val_err = 1'b1;
        if ((mode_q == MODE_TWO_TONE) & target_channel_toggle_q & (diff > TONE_DIFF))
          val_err = 1'b1;
      end
      LEVEL_PARAMETER_KEY: if (val > lim) val_err = 1'b1;
      PAR_OFS: begin
        if (val > OFS_MAX)
          val_err = 1'b1;
        if (comb_q & (wave_q[target_channel_toggle_q] != WAVE_DC))
          val_err = 1'b1;
      end
      default: if (val > PHASE_MAX) val_err = 1'b1;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      entry_q <= 1'b0;
      point_q <= 1'b0;
      param_q <= PAR_FREQ;
      mant_q  <= 32'h0;
      frac_q  <= 2'h0;
    end else if (key_ok & i_key.param_go) begin
      entry_q <= 1'b1;
      param_q <= i_key.param;
      point_q <= 1'b0;
      mant_q  <= 32'h0;
      frac_q  <= 2'h0;
    end else if (key_ok & entry_q) begin
      if (i_key.digit_go & (mant_q < MANT_LIMIT) &
          ~(point_q & (frac_q == 2'h3))) begin
        mant_q <= 32'(mant_q * 32'ha + {28'h0, i_key.digit});
        if (point_q)
          frac_q <= frac_q + 2'h1;
      end else if (i_key.point) begin
        point_q <= 1'b1;
      end else if (i_key.bksp) begin
        if (point_q & (frac_q == 2'h0)) begin
          point_q <= 1'b0;
        end else begin
          mant_q <= mant_q / 32'ha;
          if (point_q)
            frac_q <= frac_q - 2'h1;
        end
      end else if (i_key.units_go) begin
        entry_q <= 1'b0;
      end
    end
  end

  // Frequencies couple across channels, so they live outside the loop.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      freq_q[0] <= FREQ_RST;
      freq_q[1] <= FREQ_RST;
    end else if (apply & ~val_err & (param_q == PAR_FREQ)) begin
      case (mode_q)
        MODE_TWO_PH: begin
          freq_q[0] <= val;
          freq_q[1] <= val;
        end
        MODE_TWO_TONE: begin
          freq_q[target_channel_toggle_q] <= val;
          if (~target_channel_toggle_q)
            freq_q[1] <= tone_b[31:0];
        end
        default: freq_q[target_channel_toggle_q] <= val;
      endcase
    end else if (mode_go & (mode_new == MODE_TWO_PH)) begin
      freq_q[1] <= freq_q[0];
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_target_channel_toggle
    logic    fn_hit, boost_hit, boost_want, mine;
    wave_e   adv;
    assign fn_hit    = cmd.op == (ch == 0 ? OP_FN_A : OP_FN_B);
    assign boost_hit = cmd.op == (ch == 0 ? OP_BOOST_A : OP_BOOST_B);
    assign boost_want = cmd.set ? cmd.arg[0] : ~boost_q[ch];
    assign mine = apply & ~val_err & (target_channel_toggle_q == 1'(ch));
    always_comb begin
      if (mode_q == MODE_PULSE)
        adv = (wave_q[ch] == SQUARE_WAVEFORM) ? WAVE_OFF
                                              : SQUARE_WAVEFORM;
      else
        adv = wave_e'(wave_q[ch] + 2'h1);
      if (cmd.set)
        adv = wave_e'(cmd.arg);
      wave_refuse[ch] = fn_hit & cmd.set & (mode_q == MODE_PULSE) &
                        ((adv == SINE_WAVEFORM) | (adv == WAVE_DC));
      wave_go[ch]     = fn_hit & ~wave_refuse[ch];
      boost_refuse[ch] = boost_hit & boost_want &
                         (~boost_opt | (freq_q[ch] > BOOST_FMAX));
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        wave_q[ch] <= SINE_WAVEFORM;
      end else if (mode_go & (mode_new == MODE_PULSE) &
                   ((wave_q[ch] == SINE_WAVEFORM) |
                    (wave_q[ch] == WAVE_DC))) begin
        wave_q[ch] <= SQUARE_WAVEFORM;
      end else if (wave_go[ch]) begin
        wave_q[ch] <= adv;
      end
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n)
        boost_q[ch] <= 1'b0;
      else if ((ch == 1) & mode_go & (freq_q[0] > BOOST_FMAX))
        boost_q[ch] <= 1'b0;
      else if (boost_hit & ~boost_refuse[ch])
        boost_q[ch] <= boost_want;
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        ofs_q[ch]   <= 16'h0;
        level_q[ch] <= LEVEL_RST;
        phase_q[ch] <= 16'h0;
      end else begin
        if (comb_go | (comb_q & wave_go[ch] & (adv != WAVE_DC)))
          ofs_q[ch] <= 16'h0;
        else if (mine & (param_q == PAR_OFS))
          ofs_q[ch] <= val[15:0];
        if (mine & (param_q == LEVEL_PARAMETER_KEY))
          level_q[ch] <= val[15:0];
        if (comb_go & (level_q[ch] > lim[16:1]))
          level_q[ch] <= lim[16:1];
        if (mine & (param_q == PAR_PHASE))
          phase_q[ch] <= val[15:0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      err_code_q  <= 8'h0;
      err_flag_q  <= 1'b0;
      err_pulse_q <= 1'b0;
    end else begin
      err_pulse_q <= key_reject | (apply & val_err) | comb_refuse |
                     (|wave_refuse) | (|boost_refuse);
      if (key_reject) begin
        err_code_q <= ERR_REMOTE;
        err_flag_q <= 1'b1;
      end else if ((apply & val_err) | comb_refuse | (|wave_refuse) |
                   (|boost_refuse)) begin
        err_code_q <= ERR_RANGE;
        err_flag_q <= 1'b1;
      end else if (err_wr & i_pwdata[ERR_FLAG_BIT]) begin
        err_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n)
      sqr_b_q <= 1'b0;
    else
      sqr_b_q <= (mode_q == MODE_PULSE) ? ~i_sqr_a : i_sqr_b;
  end

  always_comb begin
    o_cfg_a = '0;
    o_cfg_b = '0;
    o_cfg_a.wave     = wave_q[0];
    o_cfg_b.wave     = wave_q[1];
    // Indicators are {dc, square, sine}; off shifts out and leaves all dark.
    o_cfg_a.wave_led = 3'((4'h1 << wave_q[0]) >> 1) &
                       {3{wave_q[0] != WAVE_OFF}};
    o_cfg_b.wave_led = 3'((4'h1 << wave_q[1]) >> 1) &
                       {3{wave_q[1] != WAVE_OFF}};
    o_cfg_a.boost    = boost_q[0];
    o_cfg_b.boost    = boost_q[1];
    o_cfg_a.out_en   = (seq_q == SEQ_RUN) & (wave_q[0] != WAVE_OFF);
    o_cfg_b.out_en   = (seq_q == SEQ_RUN) & (wave_q[1] != WAVE_OFF);
    o_cfg_a.dc_only  = wave_q[0] == WAVE_DC;
    o_cfg_b.dc_only  = wave_q[1] == WAVE_DC;
    o_cfg_a.freq     = freq_q[0];
    o_cfg_b.freq     = freq_q[1];
    o_cfg_a.level    = level_q[0];
    o_cfg_b.level    = level_q[1];
    o_cfg_a.ofs      = ofs_q[0];
    o_cfg_b.ofs      = ofs_q[1];
  end
  assign o_panel = '{mode_q, comb_q, |boost_q, ~target_channel_toggle_q, target_channel_toggle_q};
  assign o_mode_busy      = seq_q != SEQ_RUN;
  assign o_cal_run        = seq_q == SEQ_CAL;
  assign o_b_connector_en = ~comb_q & ~int_mod_q;
  assign o_mod_from_b     = int_mod_q & (mode_q == MODE_TWO_CH);
  assign o_sqr_out_b      = sqr_b_q;
  assign o_err_strobe     = err_pulse_q;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  chk_mode_rotate: assert property (
    mode_go & ~cmd.set |=> mode_q == $past(mode_new) && $onehot(mode_q))
    else $error("mode did not advance by one");
  chk_outputs_off: assert property (
    mode_go |=> (!o_cfg_a.out_en && !o_cfg_b.out_en && o_mode_busy) [*8])
    else $error("output enabled during mode change");
  chk_cal_start: assert property (
    seq_q == SEQ_SETTLE && cnt_q == 12'h0 && !mode_go &&
    mode_q == MODE_PULSE |=> seq_q == SEQ_CAL && cnt_q == CAL_CNT)
    else $error("calibration not started after settling");
  chk_remote_reject: assert property (
    key_reject && !cmd_wr |=> err_code_q == ERR_REMOTE && err_pulse_q &&
    $stable(mode_q) && $stable(target_channel_toggle_q))
    else $error("key acted under remote control");
  chk_pulse_wave: assert property (
    mode_q == MODE_PULSE |-> wave_q[0] inside {WAVE_OFF, SQUARE_WAVEFORM} &&
    wave_q[1] inside {WAVE_OFF, SQUARE_WAVEFORM})
    else $error("sine or dc selected in pulse mode");
  chk_comb_allowed: assert property (
    comb_q |-> mode_q != MODE_PULSE && !int_mod_q && !o_b_connector_en)
    else $error("summed output in a forbidden state");
  chk_boost_freq: assert property (
    boost_q[0] |-> freq_q[0] <= BOOST_FMAX)
    else $error("boosted channel above frequency limit");
  chk_range_err: assert property (
    apply && val_err && !key_reject ##1 1 |-> o_err_strobe &&
    err_code_q == ERR_RANGE && $stable(freq_q[0]) && $stable(level_q[0]))
    else $error("bad value accepted or error missing");
  chk_sqr_invert: assert property (
    mode_q == MODE_PULSE && $past(mode_q) == MODE_PULSE |->
    o_sqr_out_b == !$past(i_sqr_a))
    else $error("second square not inverted in pulse mode");

  cov_pulse_cal: cover property (seq_q == SEQ_CAL && mode_q == MODE_PULSE);
  cov_summed_on: cover property (comb_go);
  cov_range_err: cover property (apply && val_err);
  cov_remote_key: cover property (key_reject);
endmodule

// ---- rtl/synth_ctrl_pkg.sv ----
// Shared constants, types and register map of the two-channel control block.
package synth_ctrl_pkg;
  localparam int CLK_NS     = 10;
  localparam int SETTLE_NS  = 1000;
  localparam int CAL_NS     = 20000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_CYC    = (CAL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] SETTLE_CNT = 12'(SETTLE_CYC - 1);
  localparam logic [11:0] CAL_CNT    = 12'(CAL_CYC - 1);

  localparam logic [31:0] FREQ_MAX_HZ  = 32'h00c6_5d40;
  localparam logic [31:0] BOOST_FMAX   = 32'h000f_4240;
  localparam logic [31:0] TONE_DIFF    = 32'h0001_86a0;
  localparam logic [31:0] LEVEL_MAX    = 32'h0000_2710;
  localparam logic [31:0] BOOST_LEVEL  = 32'h0000_9c40;
  localparam logic [31:0] OFS_MAX      = 32'h0000_1388;
  localparam logic [31:0] PHASE_MAX    = 32'h0000_0168;
  localparam logic [31:0] MANT_LIMIT   = 32'h05f5_e100;
  localparam logic [31:0] FREQ_RST     = 32'h0000_03e8;
  localparam logic [15:0] LEVEL_RST    = 16'h0064;

  localparam logic [7:0] ERR_REMOTE = 8'h0b;
  localparam logic [7:0] ERR_RANGE  = 8'h14;

  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_CMD    = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_ERR    = 12'h00c;
  localparam logic [11:0] REG_FREQ_A = 12'h010;
  localparam logic [11:0] REG_FREQ_B = 12'h014;
  localparam logic [11:0] REG_LEVEL  = 12'h018;
  localparam logic [11:0] REG_OFS    = 12'h01c;
  localparam int          CTRL_INT_MOD = 0;
  localparam int          ERR_FLAG_BIT = 8;

  typedef enum logic [3:0] {
    MODE_TWO_CH = 4'b0001, MODE_TWO_PH = 4'b0010,
    MODE_TWO_TONE = 4'b0100, MODE_PULSE = 4'b1000
  } mode_e;
  typedef enum logic [2:0] {
    SEQ_RUN = 3'b001, SEQ_SETTLE = 3'b010, SEQ_CAL = 3'b100
  } seq_e;
  typedef enum logic [1:0] {
    WAVE_OFF = 2'h0, SINE_WAVEFORM = 2'h1, SQUARE_WAVEFORM = 2'h2,
    WAVE_DC = 2'h3
  } wave_e;
  typedef enum logic [1:0] {
    PAR_FREQ = 2'h0, LEVEL_PARAMETER_KEY = 2'h1, PAR_OFS = 2'h2,
    PAR_PHASE = 2'h3
  } param_e;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_MODE = 3'h1, OP_COMB = 3'h2, OP_FN_A = 3'h3,
    OP_FN_B = 3'h4, OP_BOOST_A = 3'h5, OP_BOOST_B = 3'h6, OP_TARGET_CHANNEL_TOGGLE = 3'h7
  } cmd_op_e;

  typedef struct packed {
    cmd_op_e    op;
    logic       set;
    logic [1:0] arg;
  } cmd_s;
  typedef struct packed {
    logic mode, shift, fn_a, fn_b, target_channel_toggle, param_go;
    param_e param;
    logic digit_go;
    logic [3:0] digit;
    logic point, bksp, units_go;
    logic [1:0] units;
  } key_s;
  typedef struct packed {
    wave_e      wave;
    logic [2:0] wave_led;
    logic       boost, out_en, dc_only;
    logic [31:0] freq;
    logic [15:0] level, ofs;
  } cfg_s;
  typedef struct packed {
    logic [3:0] mode_led;
    logic summed, boost_led, target_first_channel, target_second_channel;
  } panel_s;
  typedef struct packed {
    logic [15:0] zero;
    logic entry, int_mod, remote, busy, target_channel_toggle, boost_b, boost_a;
    wave_e wave_b, wave_a;
    logic summed;
    mode_e mode;
  } status_s;
endpackage

// ---- testbench/keypad_model.sv ----
// Keypad and remote controller model that sends one-cycle key pulses.
module keypad_model
  import synth_ctrl_pkg::*;
(
  input  wire logic            i_clk,
  output synth_ctrl_pkg::key_s o_key,
  output logic                 o_remote
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_key    = '0;
    o_remote = 1'b0;
  end
  // One key per cycle; a pulse is dropped at the next edge.
  task automatic press(input int k, input logic [3:0] v);
    key_s nk;
    nk = '0;
    case (k)
      0: nk.mode = 1'b1;
      1: nk.shift = 1'b1;
      2: nk.fn_a = 1'b1;
      4: nk.target_channel_toggle = 1'b1;
      5: nk.param_go = 1'b1;
      6: nk.digit_go = 1'b1;
      7: nk.bksp = 1'b1;
      8: nk.units_go = 1'b1;
      9: nk.point = 1'b1;
      default: nk.fn_b = 1'b1;
    endcase
    nk.param = param_e'(v[1:0]);
    nk.digit = v;
    nk.units = v[1:0];
    @(posedge i_clk);
    o_key <= nk;
    @(posedge i_clk);
    o_key <= '0;
  endtask
  task automatic set_remote(input logic r);
    @(posedge i_clk);
    o_remote <= r;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the two-channel control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import synth_ctrl_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sqr_a = 0;
  logic opt = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, se, rem, busy, cal, bcon, modb, sqrb, errs;
  key_s key;
  cfg_s cfg_a, cfg_b;
  panel_s panel;
  int error_cnt = 0, checks = 0, cyc = 0, nerr = 0, n0;
  keypad_model u_keys (.i_clk(clk), .o_key(key), .o_remote(rem));
  synth_ctrl u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_key(key),
    .i_remote_mode(rem), .i_boost_option(opt), .i_sqr_a(sqr_a),
    .i_sqr_b(1'b0), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_cfg_a(cfg_a),
    .o_cfg_b(cfg_b), .o_panel(panel), .o_mode_busy(busy), .o_cal_run(cal),
    .o_b_connector_en(bcon), .o_mod_from_b(modb), .o_sqr_out_b(sqrb),
    .o_err_strobe(errs));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    sqr_a <= ~sqr_a;
    if (errs === 1'b1) nerr++;
    cyc++;
    // The whole run needs about 4500 cycles.
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic hit(int k, logic [3:0] v);
    u_keys.press(k, v);
    #1;
  endtask
  task automatic idle();
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_mode();
    for (int i = 1; i <= 4; i++) begin
      hit(0, 0);
      chk("mode_led", panel.mode_led, 32'(1 << (i % 4)));
      chk("out_en", cfg_a.out_en, 0);
      chk("busy", busy, 1);
      repeat (105) @(posedge clk);
      #1;
      chk("cal", cal, i % 2);
      if (i == 3) chk("sqr_b", sqrb, sqr_a);
      idle();
    end
  endtask
  task automatic t_summed();
    hit(1, 0);
    hit(0, 0);
    chk("summed", panel.summed, 1);
    chk("mode_led", panel.mode_led, 1);
    chk("b_conn", bcon, 0);
    hit(1, 0);
    hit(0, 0);
    chk("summed", panel.summed, 0);
    idle();
  endtask
  task automatic t_func();
    // Entering pulse mode earlier left channel A on the square wave.
    logic [1:0] w[4] = '{3, 0, 1, 2};
    logic [2:0] l[4] = '{3'b100, 3'b000, 3'b001, 3'b010};
    for (int i = 0; i < 4; i++) begin
      hit(2, 0);
      chk("wave", cfg_a.wave, w[i]);
      chk("wave_led", cfg_a.wave_led, l[i]);
      chk("out_en", cfg_a.out_en, w[i] != 0);
    end
  endtask
  task automatic t_entry();
    hit(5, 1); hit(6, 2); hit(8, 1);
    chk("level", cfg_a.level, 2000);
    n0 = nerr;
    hit(5, 1); hit(6, 9); hit(6, 9); hit(8, 1);
    repeat (2) @(posedge clk);
    #1;
    chk("level", cfg_a.level, 2000);
    chk("errs", nerr - n0, 1);
    hit(5, 1); hit(6, 3); hit(6, 5); hit(7, 0); hit(8, 1);
    chk("level", cfg_a.level, 3000);
    hit(5, 1); hit(6, 1); hit(9, 0); hit(6, 5); hit(8, 1);
    chk("level", cfg_a.level, 1500);
    hit(5, 1); hit(6, 1); hit(9, 0); hit(7, 0); hit(6, 2); hit(8, 0);
    chk("level", cfg_a.level, 12);
  endtask
  task automatic t_boost();
    hit(1, 0);
    hit(2, 0);
    chk("boost", cfg_a.boost, 0);
    @(posedge clk);
    opt <= 1'b1;
    repeat (3) @(posedge clk);
    hit(1, 0);
    hit(2, 0);
    chk("boost", cfg_a.boost, 1);
    chk("boost_led", panel.boost_led, 1);
  endtask
  task automatic t_target_channel_toggle();
    hit(4, 0);
    chk("tgt_b", panel.target_second_channel, 1);
    chk("tgt_a", panel.target_first_channel, 0);
    hit(4, 0);
    chk("tgt_a", panel.target_first_channel, 1);
  endtask
  task automatic t_apb();
    apb(1, REG_CMD, 32'h39);
    @(posedge clk);
    #1;
    chk("tgt_b", panel.target_second_channel, 1);
    apb(1, REG_CMD, 32'h38);
    apb(0, 12'h100, 0);
    chk("slverr", se, 1);
    chk("rdata", rd, 0);
  endtask
  task automatic t_remote();
    u_keys.set_remote(1);
    repeat (3) @(posedge clk);
    n0 = nerr;
    hit(0, 0);
    repeat (2) @(posedge clk);
    #1;
    chk("mode_led", panel.mode_led, 1);
    chk("errs", nerr - n0, 1);
    apb(0, REG_ERR, 0);
    chk("err_reg", rd, 32'h10b);
    u_keys.set_remote(0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_mode();
    t_summed();
    t_func();
    t_entry();
    t_target_channel_toggle();
    t_boost();
    t_apb();
    t_remote();
    stop_test();
  end
endmodule
